//--- hdl/bpm_code_step.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// next block code with wrap, used for read and write codes
// ---------------------------------------------------------------
module bpm_code_step
  import bpm_pkg::*;
(
  input  wire logic [15:0] code,                     // present code
  input  wire logic [15:0] words,                    // configured word count
  output logic      [15:0] next                      // following code
);
  logic [15:0] nblk;                                 // blocks covering the area
  // blocks = ceil(words / 6); at least one so a zero count stays on block one
  always_comb begin
    nblk = 16'((32'(words) + 32'(BLK_WORDS) - 32'd1) / 32'(BLK_WORDS));
    if (nblk == 16'h0000) begin
      nblk = CODE_FIRST;
    end
    if (nblk > CODE_MAX) begin
      nblk = CODE_MAX;
    end
    if (code >= nblk) begin
      next = CODE_FIRST;
    end else begin
      next = code + 16'h0001;
    end
  end
endmodule : bpm_code_step
`default_nettype wire

//--- hdl/bpm_dev.sv
`timescale 1ns/100ps
`default_nettype none
module bpm_dev
  import bpm_pkg::*;
(
  input  wire logic                sys_clk,          // 10 MHz clock
  input  wire logic                arst_n,           // async reset, low
  bpm_if.dev                       img,              // backplane images
  input  wire logic [DB_AW-1:0]    rd_base,          // read start index
  input  wire logic [15:0]         rd_words,         // read word count
  input  wire logic [DB_AW-1:0]    wr_base,          // write start index
  input  wire logic [15:0]         wr_words,         // write word count
  input  wire logic                db_we,            // user database write
  input  wire logic [DB_AW-1:0]    db_addr,          // user database address
  input  wire logic [15:0]         db_wdata,         // user database write data
  output logic      [15:0]         db_rdata,         // read data, next cycle
  output logic                     ctl_valid,        // control block pulse
  output bpm_ctl_t                 ctl_kind,         // control class
  output logic      [15:0]         ctl_code,         // control code
  output logic      [15:0]         ctl_data [6]      // control payload
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum {S_FILL, S_HDR1, S_HDR0, S_WAIT, S_STORE} bpm_st_t;
  bpm_st_t          st_q, st_d;                      // sequencer
  logic [15:0]      db [DB_DEPTH];                   // user database
  logic [15:0]      in_q [IN_WORDS], in_d [IN_WORDS];// input image
  logic [15:0]      rd_code_q, rd_code_d;            // current read code
  logic [15:0]      wr_code_q, wr_code_d;            // current write code
  logic [15:0]      last_wr_q, last_wr_d;            // last absorbed code
  logic [2:0]       idx_q, idx_d;                    // word within block
  logic [15:0]      o0_s1_q, o0_s2_q;                // word0 synchroniser
  logic [15:0]      rd_next, wr_next;                // stepped codes
  logic             c_valid_d;                       // control pulse next
  bpm_ctl_t         c_kind_d;                        // control class next
  logic [DB_AW-1:0] rd_addr, wr_addr;                // database addresses
  logic             db_wr_img;                       // block store enable

  assign img.in_img = in_q;

  bpm_code_step u_rd_step (.code(rd_code_q), .words(rd_words), .next(rd_next));
  bpm_code_step u_wr_step (.code(wr_code_q), .words(wr_words), .next(wr_next));

  // base + (code-1)*6 + word
  assign rd_addr = DB_AW'(32'(rd_base) + (32'(rd_code_q) - 32'd1) * 32'(BLK_WORDS) + 32'(idx_q));
  assign wr_addr = DB_AW'(32'(wr_base) + (32'(last_wr_q) - 32'd1) * 32'(BLK_WORDS)
                   + 32'(idx_q));

  // ---------------------------------------------------------------
  // database: local port has priority over the block store on the same address
  // ---------------------------------------------------------------
  // both writers may land in one cycle; dropping the local write would lose
  // software data silently, so the local port wins only on the same address
  always_ff @(posedge sys_clk) begin
    if (db_wr_img) begin
      db[wr_addr] <= img.out_img[W_OUT_DATA + 32'(idx_q)];
    end
    if (db_we) begin
      db[db_addr] <= db_wdata;
    end
    db_rdata <= db[db_addr];
  end

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    in_d      = in_q;
    rd_code_d = rd_code_q;
    wr_code_d = wr_code_q;
    last_wr_d = last_wr_q;
    idx_d     = idx_q;
    db_wr_img = 1'b0;
    c_valid_d = 1'b0;
    c_kind_d  = BPM_CTL_NONE;
    unique case (st_q)
      S_FILL: begin                                  // data words first
        in_d[W_IN_DATA + 32'(idx_q)] = db[rd_addr];
        if (idx_q == 3'(BLK_WORDS - 1)) begin
          idx_d = 3'h0;
          st_d  = S_HDR1;
        end else begin
          idx_d = idx_q + 3'h1;
        end
      end
      S_HDR1: begin                                  // then write request
        in_d[W_WR_REQ] = wr_code_q;
        st_d           = S_HDR0;
      end
      S_HDR0: begin                                  // trigger last
        in_d[W_RD_CODE] = rd_code_q;
        st_d            = S_WAIT;
      end
      S_WAIT: begin
        // only a change of word0 counts as new
        if (o0_s2_q != last_wr_q) begin
          last_wr_d = o0_s2_q;
          // the read code steps after a control block too: an unchanged word0
          // would never be seen as new and the exchange would stall; needs a
          // read area of two blocks or more
          if (o0_s2_q >= CODE_POLL_LO && o0_s2_q <= CODE_POLL_HI) begin
            c_valid_d = 1'b1;
            c_kind_d  = BPM_CTL_POLL;
            rd_code_d = rd_next;
            st_d      = S_FILL;
          end else if (o0_s2_q >= CODE_CMD_LO && o0_s2_q <= CODE_CMD_HI) begin
            c_valid_d = 1'b1;
            c_kind_d  = BPM_CTL_CMD;
            rd_code_d = rd_next;
            st_d      = S_FILL;
          end else if (o0_s2_q == CODE_WARM || o0_s2_q == CODE_COLD) begin
            c_valid_d = 1'b1;
            c_kind_d  = (o0_s2_q == CODE_WARM) ? BPM_CTL_WARM : BPM_CTL_COLD;
            rd_code_d = rd_next;
            st_d      = S_FILL;
          end else if (o0_s2_q >= CODE_FIRST && o0_s2_q <= CODE_MAX) begin
            st_d = S_STORE;
          end
          // code zero or unknown: recorded, nothing moved
        end
      end
      S_STORE: begin                                 // absorb write block
        db_wr_img = 1'b1;
        if (idx_q == 3'(BLK_WORDS - 1)) begin
          idx_d     = 3'h0;
          rd_code_d = rd_next;
          wr_code_d = wr_next;
          st_d      = S_FILL;
        end else begin
          idx_d = idx_q + 3'h1;
        end
      end
      default: st_d = S_FILL;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= S_FILL;
      rd_code_q <= RST_RD_CODE;
      wr_code_q <= RST_WR_CODE;
      last_wr_q <= RST_LAST_WR;
      idx_q     <= 3'h0;
      o0_s1_q   <= 16'h0000;
      o0_s2_q   <= 16'h0000;
      ctl_valid <= 1'b0;
      ctl_kind  <= BPM_CTL_NONE;
      ctl_code  <= 16'h0000;
      for (int i = 0; i < IN_WORDS; i++) begin
        in_q[i] <= CODE_NONE;
      end
      for (int i = 0; i < BLK_WORDS; i++) begin
        ctl_data[i] <= 16'h0000;
      end
    end else begin
      st_q      <= st_d;
      rd_code_q <= rd_code_d;
      wr_code_q <= wr_code_d;
      last_wr_q <= last_wr_d;
      idx_q     <= idx_d;
      // processor may sit in another domain: two flops before use
      o0_s1_q   <= img.out_img[W_OUT_CODE];
      o0_s2_q   <= o0_s1_q;
      in_q      <= in_d;
      ctl_valid <= c_valid_d;
      ctl_kind  <= c_kind_d;
      if (c_valid_d) begin                           // payload was written with the code, two flops before the code is seen here
        ctl_code <= o0_s2_q;
        for (int i = 0; i < BLK_WORDS; i++) begin
          ctl_data[i] <= img.out_img[W_OUT_DATA + i];
        end
      end
    end
  end
endmodule : bpm_dev
`default_nettype wire

//--- hdl/bpm_if.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// backplane images joining module and processor
// ---------------------------------------------------------------
interface bpm_if;
  logic [15:0] in_img  [8];                          // written by module only
  logic [15:0] out_img [7];                          // written by processor only
  modport dev  (output in_img, input  out_img);
  modport proc (input  in_img, output out_img);
endinterface : bpm_if
`default_nettype wire

//--- hdl/bpm_pkg.sv
package bpm_pkg;
  // ---------------------------------------------------------------
  // image geometry
  // ---------------------------------------------------------------
  localparam int unsigned IN_WORDS   = 8;            // input image words
  localparam int unsigned OUT_WORDS  = 7;            // output image words
  localparam int unsigned BLK_WORDS  = 6;            // data words per block
  localparam int unsigned W_RD_CODE  = 0;            // input word of delivered code
  localparam int unsigned W_WR_REQ   = 1;            // input word of requested write code
  localparam int unsigned W_IN_DATA  = 2;            // first input data word
  localparam int unsigned W_OUT_CODE = 0;            // output word of trigger code
  localparam int unsigned W_OUT_DATA = 1;            // first output data word
  localparam int unsigned DB_DEPTH   = 4096;         // user database words
  localparam int unsigned DB_AW      = 12;           // database address width
  // ---------------------------------------------------------------
  // block codes
  // ---------------------------------------------------------------
  localparam logic [15:0] CODE_NONE   = 16'h0000;    // image carries no data
  localparam logic [15:0] CODE_FIRST  = 16'h0001;    // first data block
  localparam logic [15:0] CODE_MAX    = 16'h029a;    // 666, last data block
  localparam logic [15:0] CODE_POLL_LO = 16'h0bb8;   // 3000
  localparam logic [15:0] CODE_POLL_HI = 16'h0bb9;   // 3001
  localparam logic [15:0] CODE_CMD_LO = 16'h1388;    // 5000
  localparam logic [15:0] CODE_CMD_HI = 16'h138e;    // 5006
  localparam logic [15:0] CODE_WARM   = 16'h270e;    // 9998
  localparam logic [15:0] CODE_COLD   = 16'h270f;    // 9999
  // ---------------------------------------------------------------
  // reset values of the code registers
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_RD_CODE  = 16'h0001;   // current read code
  localparam logic [15:0] RST_WR_CODE  = 16'h0001;   // current write code
  localparam logic [15:0] RST_LAST_WR  = 16'h0000;   // last absorbed write code
  localparam logic [15:0] RST_LAST_RD  = 16'h0000;   // processor's last read code

  typedef enum logic [2:0] {
    BPM_CTL_NONE, BPM_CTL_POLL, BPM_CTL_CMD, BPM_CTL_WARM, BPM_CTL_COLD
  } bpm_ctl_t;                                       // control class of a code
endpackage : bpm_pkg

//--- hdl/bpm_proc.sv
`timescale 1ns/100ps
`default_nettype none
module bpm_proc
  import bpm_pkg::*;
(
  input  wire logic        sys_clk,                  // 10 MHz clock
  input  wire logic        arst_n,                   // async reset, low
  bpm_if.proc              img,                      // backplane images
  input  wire logic        ctl_req,                  // send a control block
  input  wire logic [15:0] ctl_code_in,              // control code to send
  input  wire logic [15:0] ctl_data_in [6],          // control payload
  input  wire logic        f_we,                     // file write
  input  wire logic [11:0] f_addr,                   // file address
  input  wire logic [15:0] f_wdata,                  // file write data
  output logic      [15:0] f_rdata,                  // read data, next cycle
  output logic             ctl_busy                  // control pending
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] rfile [DB_DEPTH];                     // read and write file
  logic [15:0] last_rd_q, last_rd_d;                 // last read code
  logic [15:0] o_q [OUT_WORDS], o_d [OUT_WORDS];     // output image
  logic [15:0] i0_s1_q, i0_s2_q;                     // word0 synchroniser
  logic        pend_q, pend_d;                       // control queued
  logic        fresh;                                // new input block
  logic [11:0] rbase, wbase;                         // file offsets

  assign img.out_img = o_q;
  assign ctl_busy    = pend_q;
  assign fresh = (i0_s2_q != last_rd_q) && (i0_s2_q != CODE_NONE);
  assign rbase = 12'((32'(i0_s2_q) - 32'd1) * 32'(BLK_WORDS));
  assign wbase = 12'((32'(img.in_img[W_WR_REQ]) - 32'd1) * 32'(BLK_WORDS));

  // file: incoming block and local port both stored, local port wins on the same address
  always_ff @(posedge sys_clk) begin
    if (fresh && i0_s2_q <= CODE_MAX) begin
      for (int i = 0; i < BLK_WORDS; i++) begin
        rfile[rbase + 12'(i)] <= img.in_img[W_IN_DATA + i];
      end
    end
    if (f_we) begin                                  // local write never dropped
      rfile[f_addr] <= f_wdata;
    end
    f_rdata <= rfile[f_addr];
  end

  // ---------------------------------------------------------------
  // next values: data then code in one update, code flop follows
  // ---------------------------------------------------------------
  always_comb begin
    last_rd_d = last_rd_q;
    o_d       = o_q;
    pend_d    = pend_q | ctl_req;
    if (fresh) begin
      last_rd_d = i0_s2_q;
      if (pend_q) begin
        for (int i = 0; i < BLK_WORDS; i++) begin
          o_d[W_OUT_DATA + i] = ctl_data_in[i];
        end
        o_d[W_OUT_CODE] = ctl_code_in;
        pend_d          = ctl_req;
      end else if (img.in_img[W_WR_REQ] >= CODE_FIRST
                   && img.in_img[W_WR_REQ] <= CODE_MAX) begin
        for (int i = 0; i < BLK_WORDS; i++) begin
          o_d[W_OUT_DATA + i] = rfile[wbase + 12'(i)];
        end
        o_d[W_OUT_CODE] = img.in_img[W_WR_REQ];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_rd_q <= RST_LAST_RD;
      i0_s1_q   <= 16'h0000;
      i0_s2_q   <= 16'h0000;
      pend_q    <= 1'b0;
      for (int i = 0; i < OUT_WORDS; i++) begin
        o_q[i] <= CODE_NONE;
      end
    end else begin
      last_rd_q <= last_rd_d;
      i0_s1_q   <= img.in_img[W_RD_CODE];
      i0_s2_q   <= i0_s1_q;
      pend_q    <= pend_d;
      o_q       <= o_d;
    end
  end
endmodule : bpm_proc
`default_nettype wire

//--- verif/block_paging_mailbox_bench.sv
`timescale 1ns/100ps
`default_nettype none
module block_paging_mailbox_bench;
  import bpm_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  localparam logic [11:0] RD_BASE = 12'h100;         // module read area start
  localparam logic [11:0] WR_BASE = 12'h200;         // module write area start
  logic        sys_clk, arst_n, db_we, f_we, ctl_req, ctl_valid, ctl_busy;
  logic [11:0] rd_base, wr_base, db_addr, f_addr;    // config and port addresses
  logic [15:0] rd_words, wr_words, db_wdata, db_rdata, f_wdata, f_rdata, ctl_code, ctl_code_in;
  logic [15:0] ctl_data [6];                         // payload seen by the module
  logic [15:0] ctl_data_in [6];                      // payload offered by the processor
  bpm_ctl_t    ctl_kind;                             // decoded control class
  logic [15:0] rd_val;                               // last word read back
  int          num_errors, checked, cycles;          // verdict counters
  logic [15:0] codes [6] = '{CODE_POLL_LO, CODE_POLL_HI, CODE_CMD_LO, CODE_CMD_HI,
                             CODE_WARM, CODE_COLD};
  bpm_ctl_t    kinds [6] = '{BPM_CTL_POLL, BPM_CTL_POLL, BPM_CTL_CMD, BPM_CTL_CMD,
                             BPM_CTL_WARM, BPM_CTL_COLD};

  bpm_if img_if ();
  bpm_dev bpm_dev_i (.sys_clk(sys_clk), .arst_n(arst_n), .img(img_if.dev),
    .rd_base(rd_base), .rd_words(rd_words), .wr_base(wr_base), .wr_words(wr_words),
    .db_we(db_we), .db_addr(db_addr), .db_wdata(db_wdata), .db_rdata(db_rdata),
    .ctl_valid(ctl_valid), .ctl_kind(ctl_kind), .ctl_code(ctl_code), .ctl_data(ctl_data));
  bpm_proc bpm_proc_i (.sys_clk(sys_clk), .arst_n(arst_n), .img(img_if.proc),
    .ctl_req(ctl_req), .ctl_code_in(ctl_code_in), .ctl_data_in(ctl_data_in), .f_we(f_we),
    .f_addr(f_addr), .f_wdata(f_wdata), .f_rdata(f_rdata), .ctl_busy(ctl_busy));
  bpm_asserts bpm_asserts_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .in_img(img_if.in_img), .out_img(img_if.out_img));

  // ---------------------------------------------------------------
  // clock, hang guard and helpers
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // the whole run needs about 1000 cycles, so 6000 means a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("[FAIL] %0t run hung", $time);
      end_sim();
    end
  end

  function automatic logic [15:0] pat(input int k);
    return 16'hc300 + 16'(k * 3);                    // distinct word per index
  endfunction

  task automatic end_sim();
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one write on the module database (f=0) or processor file (f=1)
  task automatic put(input bit f, input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    if (f) begin
      f_we <= 1'b1; f_addr <= a; f_wdata <= d;
    end else begin
      db_we <= 1'b1; db_addr <= a; db_wdata <= d;
    end
    @(posedge sys_clk);
    f_we  <= 1'b0;
    db_we <= 1'b0;
  endtask : put

  // read data is registered, so it is taken one cycle after the address
  task automatic get(input bit f, input logic [11:0] a);
    @(posedge sys_clk);
    if (f) f_addr <= a;
    else db_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    rd_val = f ? f_rdata : db_rdata;
  endtask : get

  // bounded wait on a level or pulse, sampled mid-cycle
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0, s}, {15'h0, v});
  endtask : wait_for

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0; db_we = 1'b0; f_we = 1'b0; ctl_req = 1'b0;
    db_addr = 12'h000; f_addr = 12'h000; db_wdata = 16'h0000; f_wdata = 16'h0000;
    rd_base = RD_BASE; wr_base = WR_BASE; rd_words = 16'h0012; wr_words = 16'h000c;
    ctl_code_in = 16'h0000;
    for (int i = 0; i < 6; i++) ctl_data_in[i] = 16'h0000;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    // same pattern in both source areas, so either file layout agrees
    for (int k = 0; k < 18; k++) begin
      put(1'b0, RD_BASE + 12'(k), pat(k));
      if (k < 12) put(1'b1, 12'(k), pat(k));
    end
    repeat (600) @(posedge sys_clk);
    // words 12..17 of the file come only from the third read block
    for (int k = 0; k < 18; k++) begin
      get(1'b1, 12'(k));
      chk(rd_val, pat(k));
    end
    for (int k = 0; k < 12; k++) begin
      get(1'b0, WR_BASE + 12'(k));
      chk(rd_val, pat(k));
    end
    // every control class, payload held until the processor is done
    for (int c = 0; c < 6; c++) begin
      @(posedge sys_clk);
      ctl_code_in <= codes[c];
      for (int i = 0; i < 6; i++) ctl_data_in[i] <= codes[c] + 16'(i);
      ctl_req <= 1'b1;
      @(posedge sys_clk);
      ctl_req <= 1'b0;
      wait_for(ctl_valid, 1'b1);
      chk(ctl_code, codes[c]);
      chk({13'h0, ctl_kind}, {13'h0, kinds[c]});
      chk(ctl_data[5], codes[c] + 16'h0005);
      wait_for(ctl_busy, 1'b0);
    end
    // control payloads must not have reached the user area
    for (int k = 0; k < 12; k++) begin
      get(1'b0, WR_BASE + 12'(k));
      chk(rd_val, pat(k));
    end
    end_sim();
  end
endmodule : block_paging_mailbox_bench
`default_nettype wire

//--- verif/bpm_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// image exchange checks, watching both ends from outside
// ---------------------------------------------------------------
module bpm_asserts
  import bpm_pkg::*;
(
  input  wire logic        sys_clk,                  // system clock
  input  wire logic        arst_n,                   // async reset, low
  input  wire logic [15:0] in_img  [8],              // module to processor
  input  wire logic [15:0] out_img [7]               // processor to module
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  logic [95:0] in_dat;                               // input words 2..7 packed
  logic [95:0] out_dat;                              // output words 1..6 packed

  // pack data words so one stability test covers the whole block
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      in_dat[i*16 +: 16]  = in_img[i+2];
      out_dat[i*16 +: 16] = out_img[i+1];
    end
  end

  // a new block published by the module
  sequence in_trig_s;
    $changed(in_img[0]) && in_img[0] != CODE_NONE;
  endsequence
  // a new data block answered by the processor
  sequence out_trig_s;
    $changed(out_img[0]) && out_img[0] inside {[CODE_FIRST:CODE_MAX]};
  endsequence

  first_pub_a: assert property ($rose(arst_n) |-> ##[1:12]
    (in_img[0] == RST_RD_CODE && in_img[1] == RST_WR_CODE)) else $error("first codes wrong");
  code_range_a: assert property (in_img[0] <= CODE_MAX && in_img[1] <= CODE_MAX)
    else $error("input code out of range");
  hdr_last_a: assert property (in_trig_s |-> $stable(in_dat) && $stable(in_img[1]))
    else $error("code word not written last");
  in_hold_a: assert property (in_trig_s |=> $stable(in_dat) [*4])
    else $error("input data moved too early");
  proc_reply_a: assert property (in_trig_s |-> ##[1:10]
    (out_img[0] == in_img[1] || out_img[0] > CODE_MAX)) else $error("no processor answer");
  out_hold_a: assert property (out_trig_s |=> $stable(out_dat) [*8])
    else $error("output data moved too early");
  next_pub_a: assert property (out_trig_s |-> ##[4:40] in_trig_s)
    else $error("no next block published");
  code_step_a: assert property ($changed(in_img[0]) && $past(in_img[0]) != CODE_NONE
    |-> in_img[0] == $past(in_img[0]) + 16'h0001 || in_img[0] == CODE_FIRST)
    else $error("read code did not step");
endmodule : bpm_asserts
`default_nettype wire
